// ==== hw/cod_operand_decode.sv ====
// Operand field decoder and add datapath for an 8-bit CPU.
// Assumes the opcode decoder supplies the layout and the bytes that
// follow the opcode, plus the address of the next instruction.
module cod_operand_decode (
  input logic sys_clk,
  input logic sys_rst,
  input logic decode_req,
  input cod_pkg::cod_format_t format_sel,
  input logic [cod_pkg::BYTE_W-1:0] obj_byte1,
  input logic [cod_pkg::BYTE_W-1:0] obj_byte2,
  input logic [cod_pkg::BYTE_W-1:0] obj_byte3,
  input logic [cod_pkg::ADDR_W-1:0] next_pc,
  input logic [cod_pkg::BYTE_W-1:0] working_bank_pointer,
  input logic add_req,
  input logic [cod_pkg::BYTE_W-1:0] src_value,
  input logic [cod_pkg::BYTE_W-1:0] dst_value,
  output logic decode_done,
  output logic [cod_pkg::REG_W-1:0] src_addr,
  output logic [cod_pkg::REG_W-1:0] dst_addr,
  output logic [cod_pkg::BYTE_W-1:0] immediate_operand,
  output logic [cod_pkg::BIT_W-1:0] bit_index,
  output logic polarity,
  output logic [cod_pkg::ADDR_W-1:0] direct_address_operand,
  output logic [cod_pkg::ADDR_W-1:0] branch_target,
  output logic [cod_pkg::REG_W-1:0] indexed_address,
  output logic [cod_pkg::BYTE_W-1:0] vector_operand,
  output logic operand_error,
  output logic dst_wr_en,
  output logic [cod_pkg::REG_W-1:0] dst_wr_addr,
  output logic [cod_pkg::BYTE_W-1:0] dst_wr_data,
  output logic add_carry
);

  // ************************************************************
  // Decoding helpers
  // ************************************************************
  // Working register n in the group and page of the bank pointer
  function automatic logic [cod_pkg::REG_W-1:0] work_reg(
    input logic [3:0] n,
    input logic [7:0] bank
  );
    work_reg = {bank[3:0], bank[7:4], n};
  endfunction : work_reg

  // 8-bit register field, plain or escaped
  function automatic logic [cod_pkg::REG_W-1:0] reg8(
    input logic [7:0] field,
    input logic [7:0] bank
  );
    if (field[7:4] == cod_pkg::ESC_NIBBLE) begin
      reg8 = work_reg(field[3:0], bank);
    end else begin
      reg8 = {cod_pkg::BASE_PAGE, field};
    end
  endfunction : reg8

  // Signed byte widened to an address
  function automatic logic [cod_pkg::ADDR_W-1:0] sext16(
    input logic [7:0] d
  );
    sext16 = {{8{d[7]}}, d};
  endfunction : sext16

  // ************************************************************
  // State
  // ************************************************************
  cod_pkg::cod_state_t state_reg;
  cod_pkg::cod_state_t state_next;
  logic [cod_pkg::BYTE_W:0] add_sum;

  assign add_sum = {1'b0, src_value} + {1'b0, dst_value};

  always_comb begin
    state_next = state_reg;
    state_next.done = 1'b0;
    state_next.wr_en = 1'b0;
    if (decode_req) begin
      state_next.done = 1'b1;
      state_next.err = 1'b0;
      unique case (format_sel)
        cod_pkg::FMT_REG_REG: begin
          // Object code carries source before destination
          state_next.src_addr = reg8(obj_byte1, working_bank_pointer);
          state_next.dst_addr = reg8(obj_byte2, working_bank_pointer);
        end
        cod_pkg::FMT_REG_IMM: begin
          state_next.dst_addr = reg8(obj_byte1, working_bank_pointer);
          state_next.imm = obj_byte2;
        end
        cod_pkg::FMT_EXT_EXT: begin
          // Two 12-bit addresses packed in three bytes
          state_next.src_addr = {obj_byte1, obj_byte2[7:4]};
          state_next.dst_addr = {obj_byte2[3:0], obj_byte3};
        end
        cod_pkg::FMT_BIT: begin
          state_next.pol = obj_byte1[7];
          state_next.bit_idx = obj_byte1[6:4];
          state_next.dst_addr = work_reg(obj_byte1[3:0], working_bank_pointer);
        end
        cod_pkg::FMT_DIRECT: begin
          state_next.direct = {obj_byte1, obj_byte2};
        end
        cod_pkg::FMT_RELATIVE: begin
          state_next.target = next_pc + sext16(obj_byte1);
        end
        cod_pkg::FMT_INDEXED: begin
          state_next.src_addr = reg8(obj_byte1, working_bank_pointer);
          // Wraps within the 12-bit register space
          state_next.indexed = reg8(obj_byte1, working_bank_pointer)
            + {{4{obj_byte2[7]}}, obj_byte2};
        end
        cod_pkg::FMT_REG_PAIR: begin
          state_next.src_addr = reg8(obj_byte1, working_bank_pointer);
          state_next.dst_addr = reg8(obj_byte2, working_bank_pointer);
          // Odd pair is flagged, address still passed on
          state_next.err = obj_byte1[0] | obj_byte2[0];
        end
        cod_pkg::FMT_WORK_PAIR: begin
          state_next.src_addr = work_reg(obj_byte1[3:0], working_bank_pointer);
          state_next.dst_addr = work_reg(obj_byte1[7:4], working_bank_pointer);
          state_next.err = obj_byte1[0] | obj_byte1[4];
        end
        cod_pkg::FMT_VECTOR: begin
          state_next.vector = obj_byte1;
        end
        default: begin
          state_next.err = 1'b1;
        end
      endcase
    end
    if (add_req) begin
      // Destination of the last decode is the only target
      state_next.wr_en = 1'b1;
      state_next.wr_addr = state_reg.dst_addr;
      state_next.wr_data = add_sum[cod_pkg::BYTE_W-1:0];
      state_next.carry = add_sum[cod_pkg::BYTE_W];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_reg <= cod_pkg::STATE_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign decode_done = state_reg.done;
  assign src_addr = state_reg.src_addr;
  assign dst_addr = state_reg.dst_addr;
  assign immediate_operand = state_reg.imm;
  assign bit_index = state_reg.bit_idx;
  assign polarity = state_reg.pol;
  assign direct_address_operand = state_reg.direct;
  assign branch_target = state_reg.target;
  assign indexed_address = state_reg.indexed;
  assign vector_operand = state_reg.vector;
  assign operand_error = state_reg.err;
  assign dst_wr_en = state_reg.wr_en;
  assign dst_wr_addr = state_reg.wr_addr;
  assign dst_wr_data = state_reg.wr_data;
  assign add_carry = state_reg.carry;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  sequence dec_s(cod_pkg::cod_format_t f);
    decode_req && format_sel == f;
  endsequence

  sequence add_s;
    add_req && !decode_req;
  endsequence

  source_first_a: assert property (
    dec_s(cod_pkg::FMT_REG_REG) |=> decode_done
      && src_addr == reg8($past(obj_byte1), $past(working_bank_pointer))
      && dst_addr == reg8($past(obj_byte2), $past(working_bank_pointer)))
    else $error("source field not taken first");

  plain_reg_a: assert property (
    dec_s(cod_pkg::FMT_REG_REG) && obj_byte1[7:4] != cod_pkg::ESC_NIBBLE
      |=> src_addr == {cod_pkg::BASE_PAGE, $past(obj_byte1)})
    else $error("plain register address wrong");

  escape_reg_a: assert property (
    dec_s(cod_pkg::FMT_REG_REG) && obj_byte1[7:4] == cod_pkg::ESC_NIBBLE
      |=> src_addr[3:0] == $past(obj_byte1[3:0])
      && src_addr[7:4] == $past(working_bank_pointer[7:4])
      && src_addr[11:8] == $past(working_bank_pointer[3:0]))
    else $error("escaped register not resolved");

  bit_field_a: assert property (
    dec_s(cod_pkg::FMT_BIT) |=> bit_index == $past(obj_byte1[6:4])
      && polarity == $past(obj_byte1[7]))
    else $error("bit or polarity field wrong");

  direct_addr_a: assert property (
    dec_s(cod_pkg::FMT_DIRECT)
      |=> direct_address_operand == $past({obj_byte1, obj_byte2}))
    else $error("direct address wrong");

  ext_reg_a: assert property (
    dec_s(cod_pkg::FMT_EXT_EXT)
      |=> {src_addr, dst_addr} == $past({obj_byte1, obj_byte2, obj_byte3}))
    else $error("extended register wrong");

  imm_hold_a: assert property (
    dec_s(cod_pkg::FMT_REG_IMM) ##1 (!decode_req)[*2]
      |-> immediate_operand == $past(obj_byte2, 2))
    else $error("immediate not held");

  work_pair_a: assert property (
    dec_s(cod_pkg::FMT_WORK_PAIR)
      |=> operand_error == ($past(obj_byte1[0]) | $past(obj_byte1[4])))
    else $error("working pair parity wrong");

  reg_pair_a: assert property (
    dec_s(cod_pkg::FMT_REG_PAIR)
      |=> operand_error == ($past(obj_byte1[0]) | $past(obj_byte2[0])))
    else $error("register pair parity wrong");

  rel_target_a: assert property (
    dec_s(cod_pkg::FMT_RELATIVE)
      |=> branch_target == 16'($past(next_pc) + sext16($past(obj_byte1))))
    else $error("relative target wrong");

  index_addr_a: assert property (
    dec_s(cod_pkg::FMT_INDEXED) |=> indexed_address == 12'(src_addr
      + {{4{$past(obj_byte2[7])}}, $past(obj_byte2)}))
    else $error("indexed address wrong");

  vector_byte_a: assert property (
    dec_s(cod_pkg::FMT_VECTOR) |=> vector_operand == $past(obj_byte1))
    else $error("vector wrong");

  add_write_a: assert property (
    add_s |=> dst_wr_en && dst_wr_addr == $past(dst_addr)
      && dst_wr_data == 8'($past(src_value) + $past(dst_value)))
    else $error("add result not written to destination");

  no_stray_write_a: assert property (
    !add_req |=> !dst_wr_en)
    else $error("write without add");

  done_pulse_a: assert property (
    !decode_req |=> !decode_done)
    else $error("done without request");

  imm_dst_a: assert property (
    dec_s(cod_pkg::FMT_REG_IMM)
      |=> dst_addr == reg8($past(obj_byte1), $past(working_bank_pointer)))
    else $error("immediate destination wrong");

  bit_target_a: assert property (
    dec_s(cod_pkg::FMT_BIT) |=> dst_addr == {$past(working_bank_pointer[3:0]),
      $past(working_bank_pointer[7:4]), $past(obj_byte1[3:0])})
    else $error("bit operand register wrong");

  pair_regs_a: assert property (
    dec_s(cod_pkg::FMT_WORK_PAIR) |=> src_addr[3:0] == $past(obj_byte1[3:0])
      && dst_addr[3:0] == $past(obj_byte1[7:4]))
    else $error("working pair registers wrong");

  pair_addr_a: assert property (
    dec_s(cod_pkg::FMT_REG_PAIR)
      |=> src_addr == reg8($past(obj_byte1), $past(working_bank_pointer))
      && dst_addr == reg8($past(obj_byte2), $past(working_bank_pointer)))
    else $error("register pair address wrong");

  vector_clean_a: assert property (
    dec_s(cod_pkg::FMT_VECTOR) |=> !operand_error)
    else $error("vector flagged as error");

  add_carry_a: assert property (
    add_s |=> {add_carry, dst_wr_data}
      == 9'({1'b0, $past(src_value)} + {1'b0, $past(dst_value)}))
    else $error("add carry wrong");

  bad_format_a: assert property (
    decode_req && format_sel == cod_pkg::cod_format_t'(4'hf) |=> operand_error)
    else $error("illegal layout not flagged");

endmodule : cod_operand_decode

// ==== hw/cod_pkg.sv ====
// Shared constants and types for the operand decoder.
// Assumes one core clock and a synchronous active-high reset.
package cod_pkg;

  // ************************************************************
  // Field widths
  // ************************************************************
  localparam int REG_W = 12;
  localparam int ADDR_W = 16;
  localparam int BYTE_W = 8;
  localparam int BIT_W = 3;

  // ************************************************************
  // Encodings
  // ************************************************************
  // Upper nibble that escapes to a working register
  localparam logic [3:0] ESC_NIBBLE = 4'he;
  // Page of plain 8-bit register addresses
  localparam logic [3:0] BASE_PAGE = 4'h0;

  // Operand layout chosen by the opcode
  typedef enum logic [3:0] {
    FMT_REG_REG,
    FMT_REG_IMM,
    FMT_EXT_EXT,
    FMT_BIT,
    FMT_DIRECT,
    FMT_RELATIVE,
    FMT_INDEXED,
    FMT_REG_PAIR,
    FMT_WORK_PAIR,
    FMT_VECTOR
  } cod_format_t;

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic done;
    logic [REG_W-1:0] src_addr;
    logic [REG_W-1:0] dst_addr;
    logic [BYTE_W-1:0] imm;
    logic [BIT_W-1:0] bit_idx;
    logic pol;
    logic [ADDR_W-1:0] direct;
    logic [ADDR_W-1:0] target;
    logic [REG_W-1:0] indexed;
    logic [BYTE_W-1:0] vector;
    logic err;
    logic wr_en;
    logic [REG_W-1:0] wr_addr;
    logic [BYTE_W-1:0] wr_data;
    logic carry;
  } cod_state_t;

  localparam cod_state_t STATE_RST = '0;

endpackage : cod_pkg

// ==== testbench/testbench.sv ====
// Self-checking bench for the operand decoder and its add datapath.
// Assumes cod_pkg and the decoder are compiled first.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************
  // Signals
  // ****************
  logic sys_clk = 1'b0, sys_rst = 1'b1, decode_req = 1'b0, add_req = 1'b0;
  cod_pkg::cod_format_t format_sel = cod_pkg::FMT_REG_REG;
  logic [7:0] obj_byte1 = 8'h00, obj_byte2 = 8'h00, obj_byte3 = 8'h00;
  logic [7:0] src_value = 8'h00, dst_value = 8'h00;
  logic [15:0] next_pc = 16'h0000;
  // Working regs land at 12'h53n
  logic [7:0] working_bank_pointer = 8'h35;
  logic decode_done, polarity, operand_error, dst_wr_en, add_carry;
  logic [11:0] src_addr, dst_addr, indexed_address, dst_wr_addr;
  logic [7:0] immediate_operand, vector_operand, dst_wr_data;
  logic [2:0] bit_index;
  logic [15:0] direct_address_operand, branch_target;
  int num_errors = 0, checked = 0;

  always #25 sys_clk = ~sys_clk;

  cod_operand_decode uut (
    .sys_clk, .sys_rst, .decode_req, .format_sel, .obj_byte1, .obj_byte2, .obj_byte3,
    .next_pc, .working_bank_pointer, .add_req, .src_value, .dst_value, .decode_done,
    .src_addr, .dst_addr, .immediate_operand, .bit_index, .polarity,
    .direct_address_operand, .branch_target, .indexed_address, .vector_operand,
    .operand_error, .dst_wr_en, .dst_wr_addr, .dst_wr_data, .add_carry
  );

  // ****************
  // Tasks and scenarios
  // ****************
  task step;
    @(posedge sys_clk);
    #1;
  endtask : step
  task check_val(input logic [15:0] got, exp, input string what);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check_val
  task decode(input cod_pkg::cod_format_t f, input logic [7:0] a, b, c);
    step();
    format_sel = f;
    obj_byte1 = a;
    obj_byte2 = b;
    obj_byte3 = c;
    decode_req = 1'b1;
    step();
    decode_req = 1'b0;
    check_val(decode_done, 1'b1, "done");
  endtask : decode
  task do_add(input logic [7:0] s, d, input logic [11:0] a, input logic [8:0] sum);
    step();
    src_value = s;
    dst_value = d;
    add_req = 1'b1;
    step();
    add_req = 1'b0;
    check_val(dst_wr_en, 1'b1, "wr_en");
    check_val(dst_wr_addr, a, "wr_addr");
    check_val({add_carry, dst_wr_data}, sum, "sum");
    step();
    check_val(dst_wr_en, 1'b0, "wr_en pulse");
  endtask : do_add
  task test_reg_fields;
    decode(cod_pkg::FMT_REG_REG, 8'h08, 8'h43, 8'h00);
    check_val(src_addr, 12'h008, "src first");
    check_val(dst_addr, 12'h043, "dst second");
    check_val(operand_error, 1'b0, "no error");
    step();
    check_val(decode_done, 1'b0, "done pulse");
    decode(cod_pkg::FMT_REG_REG, 8'he8, 8'hff, 8'h00);
    check_val(src_addr, 12'h538, "escaped src");
    check_val(dst_addr, 12'h0ff, "top plain reg");
    decode(cod_pkg::FMT_EXT_EXT, 8'hff, 8'hf0, 8'h00);
    check_val(src_addr, 12'hfff, "ext src max");
    check_val(dst_addr, 12'h000, "ext dst min");
    decode(cod_pkg::FMT_REG_IMM, 8'h43, 8'hff, 8'h00);
    check_val(dst_addr, 12'h043, "imm dst");
    check_val(immediate_operand, 8'hff, "imm");
    repeat (2) step();
    check_val(immediate_operand, 8'hff, "imm held");
  endtask : test_reg_fields
  task test_bit_fields;
    decode(cod_pkg::FMT_BIT, 8'hf5, 8'h00, 8'h00);
    check_val(polarity, 1'b1, "pol one");
    check_val(bit_index, 3'h7, "bit seven");
    check_val(dst_addr, 12'h535, "bit wreg");
    decode(cod_pkg::FMT_BIT, 8'h0a, 8'h00, 8'h00);
    check_val(polarity, 1'b0, "pol zero");
    check_val(bit_index, 3'h0, "bit zero");
  endtask : test_bit_fields
  task test_addresses;
    decode(cod_pkg::FMT_DIRECT, 8'hff, 8'h01, 8'h00);
    check_val(direct_address_operand, 16'hff01, "direct");
    next_pc = 16'h0010;
    decode(cod_pkg::FMT_RELATIVE, 8'h80, 8'h00, 8'h00);
    check_val(branch_target, 16'hff90, "rel -128");
    decode(cod_pkg::FMT_RELATIVE, 8'h7f, 8'h00, 8'h00);
    check_val(branch_target, 16'h008f, "rel +127");
    decode(cod_pkg::FMT_INDEXED, 8'h10, 8'hff, 8'h00);
    check_val(indexed_address, 12'h00f, "index -1");
    decode(cod_pkg::FMT_INDEXED, 8'h10, 8'h7f, 8'h00);
    check_val(indexed_address, 12'h08f, "index +127");
    decode(cod_pkg::FMT_VECTOR, 8'hff, 8'h00, 8'h00);
    check_val(vector_operand, 8'hff, "vector");
  endtask : test_addresses
  task test_pairs;
    decode(cod_pkg::FMT_REG_PAIR, 8'hfe, 8'h02, 8'h00);
    check_val(operand_error, 1'b0, "even pair");
    decode(cod_pkg::FMT_REG_PAIR, 8'h02, 8'hff, 8'h00);
    check_val(operand_error, 1'b1, "odd pair");
    decode(cod_pkg::FMT_WORK_PAIR, 8'he0, 8'h00, 8'h00);
    check_val(operand_error, 1'b0, "even wpair");
    decode(cod_pkg::FMT_WORK_PAIR, 8'h0f, 8'h00, 8'h00);
    check_val(operand_error, 1'b1, "odd wpair");
    decode(cod_pkg::cod_format_t'(4'hf), 8'h00, 8'h00, 8'h00);
    check_val(operand_error, 1'b1, "bad format");
  endtask : test_pairs
  task test_add;
    decode(cod_pkg::FMT_REG_REG, 8'h08, 8'h43, 8'h00);
    do_add(8'h01, 8'h02, 12'h043, 9'h003);
    do_add(8'hff, 8'h01, 12'h043, 9'h100);
  endtask : test_add
  task complete_run;
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (16) step();
    sys_rst = 1'b0;
    test_reg_fields();
    test_bit_fields();
    test_addresses();
    test_pairs();
    test_add();
    complete_run();
  end

  // Run needs under 200 cycles; wide margin
  initial begin
    #100us;
    num_errors++;
    complete_run();
  end

endmodule : testbench
